/* logic/pcs_top.sv */
`timescale 1ns/1ps
module pcs_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cfi_sync,
  input wire logic cfi_slot_stb,
  input wire pcs_pkg::pcs_byte_t cfi_rx,
  input wire pcs_pkg::pcs_byte_t pcm_rx,
  input wire pcs_pkg::pcs_byte_t monitor_tx,
  input wire logic [1:0] monitor_hs,
  output pcs_pkg::pcs_byte_t cfi_tx,
  output pcs_pkg::pcs_byte_t cfi_tx_oe_n,
  output pcs_pkg::pcs_byte_t pcm_tx,
  output pcs_pkg::pcs_byte_t pcm_tx_oe_n,
  output logic irq
);
  import pcs_pkg::*;

  // Pin synchronisers, second stage is read by logic, plus a third stage for the sync and strobe edges
  logic [17:0] meta_q;
  logic [17:0] pin_q;
  logic [1:0] edge_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= 18'h0;
      pin_q <= 18'h0;
      edge_q <= 2'h0;
    end else begin
      meta_q <= {cfi_sync, cfi_slot_stb, cfi_rx, pcm_rx};
      pin_q <= meta_q;
      edge_q <= pin_q[17:16];
    end
  end
  wire [7:0] rx_s = pin_q[15:8];
  wire [7:0] prx_s = pin_q[7:0];
  wire frame_edge = pin_q[17] & ~edge_q[1];
  wire slot_edge = pin_q[16] & ~edge_q[0];

  // Software registers and state
  logic [7:0] data_q;
  logic [7:0] addr_q;
  logic [7:0] cfg_q;
  logic [2:0] stat_q;
  logic [2:0] mask_q;
  logic irq_q;
  logic busy_q;
  logic pend_cm_q;
  logic [4:0] pend_a_q;
  logic [3:0] pend_k_q;
  logic [7:0] pend_v_q;
  logic [3:0] slot_q;
  logic [3:0] fcnt_q;
  logic tick_q;
  logic [3:0] cm_code_q [2*NSLOT];
  logic [7:0] cm_data_q [2*NSLOT];
  logic [7:0] dm_ts_q [NSLOT];
  logic [7:0] pcm_in_q [NSLOT];
  logic [7:0] pcm_out_q [NSLOT];
  logic [7:0] cfi_tx_q;
  logic [7:0] cfi_oe_n_q;
  logic [7:0] pcm_tx_q;
  logic [7:0] pcm_oe_n_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic q_valid;
  logic [3:0] q_head;
  logic q_ovf;

  // Outputs straight from flip-flops
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign cfi_tx = cfi_tx_q;
  assign cfi_tx_oe_n = cfi_oe_n_q;
  assign pcm_tx = pcm_tx_q;
  assign pcm_tx_oe_n = pcm_oe_n_q;
  assign irq = irq_q;

  // Location pair of the current slot, even half and odd half
  wire ev = ~slot_q[0];
  wire [3:0] e_i = {slot_q[3:1], 1'b0};
  wire [3:0] o_i = {slot_q[3:1], 1'b1};
  wire [3:0] de_c = cm_code_q[{1'b0, e_i}];
  wire [7:0] de_d = cm_data_q[{1'b0, e_i}];
  wire [3:0] do_c = cm_code_q[{1'b0, o_i}];
  wire [7:0] do_d = cm_data_q[{1'b0, o_i}];
  wire [3:0] ue_c = cm_code_q[{1'b1, e_i}];
  wire [7:0] ue_d = cm_data_q[{1'b1, e_i}];
  wire [3:0] uo_c = cm_code_q[{1'b1, o_i}];
  wire [7:0] uo_d = cm_data_q[{1'b1, o_i}];

  // Handshake bits: monitor handler or forced ones
  wire [1:0] sel = cfg_q[CFG_SEL +: 2];
  wire [1:0] dpos = 2'(2'h3 - sel);
  wire [1:0] hs = cfg_q[CFG_HS] ? monitor_hs : HS_ONES; // see [RULE1] [RULE2] [RULE13]

  // Downstream decode of the pair
  wire is_cen_d = (de_c == C_PRE) && (do_c[3:2] == C_SUB); // see [RULE3] [RULE7]
  wire is_tr_d = (de_c == C_PRE) && (do_c == C_64K); // see [RULE9]
  wire is_sig_d = (de_c == C_PRE) && (do_c == C_OFF); // see [RULE15] [RULE8]
  wire is_dec_d = (de_c == C_DEC) && (do_c == C_OFF); // see [RULE7]
  wire mon_on = (de_c == C_PRE) || (de_c == C_DEC);
  wire [7:0] pin_b = pcm_in_q[do_d[3:0]];
  wire [1:0] pin_sub = get2(pin_b, do_c[1:0]); // see [RULE7]
  wire [7:0] ctl_b = {de_d[7:2], hs};
  wire [7:0] cen_b = put2(ctl_b, dpos, pin_sub); // see [RULE6]
  wire [1:0] tr_lo = pin_b[1:0] & hs; // see [RULE10]
  wire [7:0] tx_d = ev ? monitor_tx :
                    is_cen_d ? cen_b :
                    is_tr_d ? {pin_b[7:2], tr_lo} : ctl_b;
  // Decentral pair floats only the D bits so an outside controller can drive
  wire [7:0] oe_d = ev ? (mon_on ? B_ZERO : B_HIZ) :
                    (is_cen_d | is_tr_d | is_sig_d) ? B_ZERO :
                    is_dec_d ? put2(B_ZERO, dpos, HS_ONES) : B_HIZ;

  // Upstream decode of the pair
  wire is_sub_u = (uo_c[3:2] == C_SUB);
  wire is_tr_u = (uo_c == C_64K);
  wire [3:0] uptr = uo_d[3:0];
  wire [1:0] rx_sub = get2(rx_s, dpos);
  wire [7:0] pout_new = is_tr_u ? rx_s :
                        put2(pcm_out_q[uptr], uo_c[1:0], rx_sub); // see [RULE3]
  wire up_go = slot_edge & ~ev & (is_sub_u | is_tr_u); // see [RULE9]
  wire ci_ev = slot_edge & ~ev & (ue_c == C_DEC) &
               (rx_s[5:2] != ue_d[5:2]); // see [RULE4]
  wire is_sig_u = (ue_c == C_PRE) && (uo_c == C_PRE);
  wire sig_look = slot_edge & ~ev & is_sig_u & tick_q; // see [RULE14]
  // Change is valid only when two looks a period apart agree
  wire sig_ev = sig_look & (rx_s[7:2] == ue_d[7:2]) &
                (rx_s[7:2] != uo_d[7:2]); // see [RULE14] [RULE15]

  // APB decode
  wire acc = psel & penable;
  wire done = acc & pready_q;
  wire wr = done & pwrite;
  wire rd = done & ~pwrite;
  wire hit = (paddr == A_DATA) | (paddr == A_ADDR) | (paddr == A_CMD) |
             (paddr == A_CFG) | (paddr == A_STAT) | (paddr == A_MASK) |
             (paddr == A_QUEUE) | (paddr == A_BUSY);
  wire cmd_wr = wr & (paddr == A_CMD) & ~busy_q;
  wire take_cm = cmd_wr & (pwdata[7:4] == K_WR_CM); // see [RULE11]
  wire take_dm = cmd_wr & (pwdata[7:0] == K_WR_DM); // see [RULE12]
  wire apply = frame_edge & busy_q; // see [RULE16]
  wire apply_cm = apply & pend_cm_q;
  wire apply_dm = apply & ~pend_cm_q;
  wire [2:0] w1c = (wr & (paddr == A_STAT)) ? pwdata[2:0] : 3'h0;
  wire [2:0] stat_d = (stat_q & ~w1c) | {q_ovf, sig_ev, ci_ev};
  wire q_pop = rd & (paddr == A_QUEUE) & prdata_q[Q_VALID];
  wire [7:0] rd_mux = (paddr == A_DATA) ? data_q :
                      (paddr == A_ADDR) ? addr_q :
                      (paddr == A_CFG) ? cfg_q :
                      (paddr == A_STAT) ? {5'h0, stat_q} :
                      (paddr == A_MASK) ? {5'h0, mask_q} :
                      (paddr == A_QUEUE) ? {q_valid, 3'h0, q_head} :
                      (paddr == A_BUSY) ? {7'h0, busy_q} : B_ZERO;

  // Bus slave: one wait state so read data can come from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end else begin
      pready_q <= acc & ~pready_q;
      if (acc & ~pready_q) begin
        pslverr_q <= ~hit;
        prdata_q <= {24'h0, rd_mux};
      end
    end
  end

  // Plain registers; status set wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_q <= B_ZERO;
      addr_q <= B_ZERO;
      cfg_q <= B_ZERO;
      mask_q <= 3'h0;
      stat_q <= 3'h0;
      irq_q <= 1'b0;
    end else begin
      if (wr & (paddr == A_DATA)) data_q <= pwdata[7:0];
      if (wr & (paddr == A_ADDR)) addr_q <= pwdata[7:0];
      if (wr & (paddr == A_CFG)) cfg_q <= pwdata[7:0];
      if (wr & (paddr == A_MASK)) mask_q <= pwdata[2:0];
      stat_q <= stat_d;
      irq_q <= |(stat_q & mask_q);
    end
  end

  // Staged memory command; busy blocks a second one until frame start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_q <= 1'b0;
      pend_cm_q <= 1'b0;
      pend_a_q <= 5'h0;
      pend_k_q <= C_UNUSED;
      pend_v_q <= B_ZERO;
    end else if (take_cm | take_dm) begin
      busy_q <= 1'b1; // see [RULE16]
      pend_cm_q <= take_cm;
      pend_a_q <= {addr_q[ADR_DIR], addr_q[3:0]};
      pend_k_q <= pwdata[3:0]; // see [RULE11]
      pend_v_q <= data_q;
    end else if (apply) begin
      busy_q <= 1'b0;
    end
  end

  // Slot counter and filter period tick, counted in frames
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slot_q <= 4'h0;
      fcnt_q <= 4'h0;
      tick_q <= 1'b0;
    end else if (frame_edge) begin
      slot_q <= 4'h0;
      tick_q <= (fcnt_q == cfg_q[CFG_PER +: 4]); // see [RULE14]
      fcnt_q <= (fcnt_q == cfg_q[CFG_PER +: 4]) ? 4'h0 :
                4'(fcnt_q + 4'h1);
    end else if (slot_edge) begin
      slot_q <= 4'(slot_q + 4'h1);
    end
  end

  // Control memory: hardware updates, then software apply wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 2*NSLOT; i++) begin
        cm_code_q[i] <= C_UNUSED;
        cm_data_q[i] <= B_ZERO;
      end
    end else begin
      if (ci_ev) cm_data_q[{1'b1, e_i}] <= {ue_d[7:6], rx_s[5:2], ue_d[1:0]};
      if (sig_look) cm_data_q[{1'b1, e_i}] <= {rx_s[7:2], ue_d[1:0]};
      if (sig_ev) cm_data_q[{1'b1, o_i}] <= {rx_s[7:2], uo_d[1:0]};
      if (apply_cm) begin
        cm_code_q[pend_a_q] <= pend_k_q; // see [RULE16]
        cm_data_q[pend_a_q] <= pend_v_q;
      end
    end
  end

  // PCM side buffers and tristate masks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NSLOT; i++) begin
        dm_ts_q[i] <= B_ZERO;
        pcm_in_q[i] <= B_HIZ;
        pcm_out_q[i] <= B_HIZ;
      end
    end else begin
      if (slot_edge) pcm_in_q[slot_q] <= prx_s;
      if (up_go) pcm_out_q[uptr] <= pout_new;
      if (apply_dm) dm_ts_q[pend_a_q[3:0]] <= pend_v_q; // see [RULE12]
    end
  end

  // Pin drivers refresh once per slot; PCM idle is all high-Z
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfi_tx_q <= B_HIZ;
      cfi_oe_n_q <= B_HIZ;
      pcm_tx_q <= B_HIZ;
      pcm_oe_n_q <= B_HIZ;
    end else if (slot_edge) begin
      cfi_tx_q <= tx_d;
      cfi_oe_n_q <= oe_d;
      pcm_tx_q <= pcm_out_q[slot_q];
      pcm_oe_n_q <= ~dm_ts_q[slot_q]; // see [RULE12]
    end
  end

  // Addresses of changed slots wait here for software
  pcs_change_queue u_queue (
    .pclk(pclk),
    .presetn(presetn),
    .push(ci_ev | sig_ev), // see [RULE4] [RULE14]
    .push_addr(slot_q),
    .pop(q_pop),
    .valid(q_valid),
    .head(q_head),
    .ovf(q_ovf)
  );

  // Checks on the slot pipeline and register side
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_hs_mon;
    slot_edge && !ev && cfg_q[CFG_HS] && (is_cen_d || is_sig_d)
      |=> cfi_tx_q[1:0] == $past(monitor_hs);
  endproperty
  a_hs_mon: assert property (p_hs_mon) // see [RULE1]
    else $error("handshake bits not from monitor handler");

  property p_hs_one;
    slot_edge && !ev && !cfg_q[CFG_HS] && is_cen_d
      |=> cfi_tx_q[1:0] == HS_ONES && cfi_oe_n_q == B_ZERO;
  endproperty
  a_hs_one: assert property (p_hs_one) // see [RULE2]
    else $error("handshake bits not forced high");

  property p_dbits;
    slot_edge && !ev && is_cen_d && sel == 2'h0
      |=> cfi_tx_q[7:6] == $past(pin_sub);
  endproperty
  a_dbits: assert property (p_dbits) // see [RULE3]
    else $error("D bits not taken from PCM subslot");

  property p_ci;
    ci_ev |=> stat_q[ST_CI] ##1 (irq_q || !$past(mask_q[ST_CI]));
  endproperty
  a_ci: assert property (p_ci) // see [RULE4]
    else $error("C/I change not flagged");

  property p_float;
    slot_edge && !ev && is_dec_d && sel == 2'h0
      |=> cfi_oe_n_q[7:6] == HS_ONES && cfi_oe_n_q[5:0] == 6'h0;
  endproperty
  a_float: assert property (p_float) // see [RULE7]
    else $error("D bits not floated");

  property p_trans;
    slot_edge && !ev && is_tr_d |=> cfi_tx_q[1:0] == $past(tr_lo);
  endproperty
  a_trans: assert property (p_trans) // see [RULE10]
    else $error("transparent low bits not ANDed");

  property p_take;
    take_cm |=> busy_q && pend_cm_q && pend_k_q == $past(pwdata[3:0]);
  endproperty
  a_take: assert property (p_take) // see [RULE11]
    else $error("memory write command not taken");

  property p_dm;
    take_dm |=> busy_q && !pend_cm_q;
  endproperty
  a_dm: assert property (p_dm) // see [RULE12]
    else $error("tristate command not taken");

  property p_sig_tick;
    sig_ev |-> tick_q ##1 stat_q[ST_SIG];
  endproperty
  a_sig_tick: assert property (p_sig_tick) // see [RULE14]
    else $error("signaling change outside filter look");

  property p_hold;
    busy_q && !frame_edge |=> busy_q && $stable(pend_v_q);
  endproperty
  a_hold: assert property (p_hold) // see [RULE16]
    else $error("staged write applied mid frame");

  c_pop2: cover property (q_pop ##1 q_valid);
  c_sig: cover property (sig_ev);
  c_apply: cover property (take_cm ##[1:1000] apply_cm);
  c_trans: cover property (slot_edge && !ev && is_tr_d);
endmodule : pcs_top

/* shared/pcs_pkg.sv */
// How it works
// [RULE1] In handshake mode the two handshake bits of the odd slot come from the monitor handler.
// [RULE2] Without handshake the central scheme sends both handshake bits as 1 beside the C/I field.
// [RULE3] The central scheme carries the two D bits to and from a chosen PCM slot both ways.
// [RULE4] An upstream C/I value that differs from last frame's raises an event and queues the slot.
// [RULE5] Software programs even down 1010, even up 1000 and both odd locations with a switch code.
// [RULE6] D bits sit at slot bits 7..6, so the subslot select field is meant to stay 00.
// [RULE7] Subslot codes 0111..0100 pick PCM bits 7-6 down to 1-0; 1011 downstream floats the D bits.
// [RULE8] Software may send an idle D pattern by moving the downstream pair to the signaling scheme.
// [RULE9] Odd code 0001 switches the whole odd slot to and from a PCM slot while the monitor runs.
// [RULE10] In that transparent mode the two PCM low bits are ANDed with the handshake bits downstream.
// [RULE11] Command 0111 in the upper nibble writes code (lower nibble) and data of a control location.
// [RULE12] Command 0110 0000 writes the tristate mask of a PCM slot, a 1 bit drives that bit.
// [RULE13] Without handshake the signaling scheme sends both handshake bits as 1 beside the field.
// [RULE14] Upstream signaling changes pass a double last look filter with a programmable period.
// [RULE15] In the signaling scheme the even upstream location holds the actual, the odd the stable value.
// [RULE16] A control location written by software takes effect whole at the next frame start.
package pcs_pkg;
  localparam int NSLOT = 16;
  localparam int QDEPTH = 8;
  typedef logic [7:0] pcs_byte_t;
  // Register byte offsets
  localparam logic [7:0] A_DATA = 8'h00;
  localparam logic [7:0] A_ADDR = 8'h04;
  localparam logic [7:0] A_CMD = 8'h08;
  localparam logic [7:0] A_CFG = 8'h0C;
  localparam logic [7:0] A_STAT = 8'h10;
  localparam logic [7:0] A_MASK = 8'h14;
  localparam logic [7:0] A_QUEUE = 8'h18;
  localparam logic [7:0] A_BUSY = 8'h1C;
  // Control memory codes
  localparam logic [3:0] C_UNUSED = 4'h0;
  localparam logic [3:0] C_64K = 4'h1;
  localparam logic [1:0] C_SUB = 2'h1;
  localparam logic [3:0] C_DEC = 4'h8;
  localparam logic [3:0] C_PRE = 4'hA;
  localparam logic [3:0] C_OFF = 4'hB;
  // Memory access commands
  localparam logic [3:0] K_WR_CM = 4'h7;
  localparam logic [7:0] K_WR_DM = 8'h60;
  // Field positions
  localparam int ADR_DIR = 7;
  localparam int CFG_HS = 0;
  localparam int CFG_SEL = 2;
  localparam int CFG_PER = 4;
  localparam int ST_CI = 0;
  localparam int ST_SIG = 1;
  localparam int ST_OVF = 2;
  localparam int Q_VALID = 7;
  // Reset and drive values
  localparam logic [7:0] B_ZERO = 8'h00;
  localparam logic [7:0] B_HIZ = 8'hFF;
  localparam logic [1:0] HS_ONES = 2'h3;

  // Two-bit subslot i of a byte, i = 3 is bits 7..6
  function automatic logic [1:0] get2(input logic [7:0] b,
                                      input logic [1:0] i);
    return b[2*i +: 2];
  endfunction : get2

  function automatic logic [7:0] put2(input logic [7:0] b,
                                      input logic [1:0] i,
                                      input logic [1:0] v);
    logic [7:0] r;
    r = b;
    r[2*i +: 2] = v;
    return r;
  endfunction : put2
endpackage : pcs_pkg

/* logic/pcs_change_queue.sv */
`timescale 1ns/1ps
module pcs_change_queue (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic push,
  input wire logic [3:0] push_addr,
  input wire logic pop,
  output logic valid,
  output logic [3:0] head,
  output logic ovf
);
  import pcs_pkg::*;
  logic [3:0] mem_q [QDEPTH];
  logic [2:0] wp_q;
  logic [2:0] rp_q;
  logic [3:0] cnt_q;
  logic ovf_q;
  wire full = (cnt_q == 4'(QDEPTH));
  wire do_push = push & ~full;
  wire do_pop = pop & valid;

  // Outputs of the queue head
  assign valid = (cnt_q != 4'h0);
  assign head = mem_q[rp_q];
  assign ovf = ovf_q;

  // A full queue drops the new address and reports it once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_q <= 3'h0;
      rp_q <= 3'h0;
      cnt_q <= 4'h0;
      ovf_q <= 1'b0;
      for (int i = 0; i < QDEPTH; i++) begin
        mem_q[i] <= 4'h0;
      end
    end else begin
      ovf_q <= push & full;
      if (do_push) begin
        mem_q[wp_q] <= push_addr;
        wp_q <= 3'(wp_q + 3'h1);
      end
      if (do_pop) begin
        rp_q <= 3'(rp_q + 3'h1);
      end
      cnt_q <= 4'(cnt_q + {3'h0, do_push} - {3'h0, do_pop});
    end
  end
endmodule : pcs_change_queue

/* verification/pcs_far_end.sv */
`timescale 1ns/1ps
module pcs_far_end (
  input wire logic pclk,
  output logic cfi_sync,
  output logic cfi_slot_stb,
  output pcs_pkg::pcs_byte_t cfi_rx,
  output pcs_pkg::pcs_byte_t pcm_rx,
  input wire pcs_pkg::pcs_byte_t cfi_tx,
  input wire pcs_pkg::pcs_byte_t cfi_tx_oe_n,
  input wire pcs_pkg::pcs_byte_t pcm_tx,
  input wire pcs_pkg::pcs_byte_t pcm_tx_oe_n
);
  import pcs_pkg::*;
  pcs_byte_t up [NSLOT];
  pcs_byte_t pcm [NSLOT];
  pcs_byte_t got_tx [NSLOT];
  pcs_byte_t got_oe [NSLOT];
  pcs_byte_t got_ptx [NSLOT];
  pcs_byte_t got_poe [NSLOT];

  // Lines idle low, tables cleared
  initial begin
    cfi_sync = 1'b0;
    cfi_slot_stb = 1'b0;
    cfi_rx = 8'h00;
    pcm_rx = 8'h00;
    for (int i = 0; i < NSLOT; i++) begin
      up[i] = 8'h00;
      pcm[i] = 8'h00;
    end
  end

  // One frame: sync, then a strobe per slot with the answer captured
  task automatic run_frame();
    @(posedge pclk);
    cfi_sync <= 1'b1;
    repeat (4) @(posedge pclk);
    cfi_sync <= 1'b0;
    for (int s = 0; s < NSLOT; s++) begin
      repeat (2) @(posedge pclk);
      cfi_rx <= up[s];
      pcm_rx <= pcm[s];
      repeat (3) @(posedge pclk);
      cfi_slot_stb <= 1'b1;
      repeat (6) @(posedge pclk);
      got_tx[s] = cfi_tx;
      got_oe[s] = cfi_tx_oe_n;
      got_ptx[s] = pcm_tx;
      got_poe[s] = pcm_tx_oe_n;
      cfi_slot_stb <= 1'b0;
      // Between slots the data is stale, so show its inverse
      cfi_rx <= ~up[s];
      pcm_rx <= ~pcm[s];
    end
  endtask : run_frame
endmodule : pcs_far_end

/* verification/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import pcs_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
  logic cfi_sync, cfi_slot_stb;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] monitor_hs, hs;
  pcs_byte_t cfi_rx, pcm_rx, monitor_tx, cfi_tx, cfi_tx_oe_n;
  pcs_byte_t pcm_tx, pcm_tx_oe_n, want;
  int fails, comparisons;

  pcs_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cfi_sync(cfi_sync), .cfi_slot_stb(cfi_slot_stb), .cfi_rx(cfi_rx),
    .pcm_rx(pcm_rx), .monitor_tx(monitor_tx), .monitor_hs(monitor_hs),
    .cfi_tx(cfi_tx), .cfi_tx_oe_n(cfi_tx_oe_n), .pcm_tx(pcm_tx),
    .pcm_tx_oe_n(pcm_tx_oe_n), .irq(irq));

  pcs_far_end far (.pclk(pclk), .cfi_sync(cfi_sync),
    .cfi_slot_stb(cfi_slot_stb), .cfi_rx(cfi_rx), .pcm_rx(pcm_rx),
    .cfi_tx(cfi_tx), .cfi_tx_oe_n(cfi_tx_oe_n), .pcm_tx(pcm_tx),
    .pcm_tx_oe_n(pcm_tx_oe_n));

  // 20 MHz clock
  always #25 pclk = ~pclk;

  task automatic give_verdict();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input string what, input logic [7:0] seen,
                     input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // One APB transfer; the request is held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      fails++;
      give_verdict();
    end
  endtask : apb

  // Staged memory command; it only lands at the next frame start
  task automatic cmd(input logic [7:0] a, input logic [7:0] c,
                     input logic [7:0] d);
    apb(1'b1, A_DATA, {24'h0, d});
    apb(1'b1, A_ADDR, {24'h0, a});
    apb(1'b1, A_CMD, {24'h0, c});
    apb(1'b0, A_BUSY, 32'h0);
    chk("busy staged", rd[7:0], 8'h01);
    far.run_frame();
    apb(1'b0, A_BUSY, 32'h0);
    chk("busy cleared", rd[7:0], 8'h00);
  endtask : cmd

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    monitor_tx = 8'h3C;
    monitor_hs = 2'b10;
    fails = 0;
    comparisons = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    chk("cfi_tx reset", cfi_tx, B_HIZ);
    chk("pcm_tx_oe_n reset", pcm_tx_oe_n, B_HIZ);
    apb(1'b0, A_STAT, 32'h0);
    chk("status reset", rd[7:0], 8'h00);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped error", {7'h0, err}, 8'h01);
    chk("unmapped data", rd[7:0], 8'h00);
    $display("test reset done");
    // Far side: D 01, C/I 0110 upstream; handshake bits sent as 1
    far.up[3] = 8'h5B;
    // Slot 15 sends signaling 010001, unlike the expected 110111
    far.up[15] = 8'h47;
    far.pcm[5] = 8'hE4;
    far.pcm[12] = 8'h57;
    apb(1'b1, A_CFG, 32'h0);
    for (int p = 0; p < 4; p++) begin
      cmd(8'(2*p+2), {K_WR_CM, C_PRE}, 8'hD7);
      cmd(8'(2*p+3), {K_WR_CM, 4'(7-p)}, 8'h05);
    end
    cmd(8'h0A, {K_WR_CM, C_DEC}, 8'hD7);
    cmd(8'h0B, {K_WR_CM, C_OFF}, 8'h00);
    cmd(8'h0C, {K_WR_CM, C_PRE}, 8'hD7);
    cmd(8'h0D, {K_WR_CM, C_64K}, 8'h0C);
    cmd(8'h0E, {K_WR_CM, C_PRE}, 8'hB7);
    cmd(8'h0F, {K_WR_CM, C_OFF}, 8'h00);
    cmd(8'h82, {K_WR_CM, C_DEC}, 8'hFF);
    cmd(8'h83, {K_WR_CM, 4'h5}, 8'h08);
    // Two agreeing looks are needed, so the change shows a frame later
    cmd(8'h8E, {K_WR_CM, C_PRE}, 8'hDF);
    cmd(8'h8F, {K_WR_CM, C_PRE}, 8'hDF);
    cmd(8'h08, K_WR_DM, 8'h0C);
    $display("test programming done");
    // Both handshake modes, two frames each so PCM buffers are full
    for (int m = 0; m < 2; m++) begin
      hs = (m == 1) ? monitor_hs : HS_ONES;
      apb(1'b1, A_CFG, 32'(m));
      far.run_frame();
      far.run_frame();
      chk("hs bits", far.got_tx[3] & 8'h03, {6'h0, hs});
      for (int p = 0; p < 4; p++) begin
        want = {2'(3 - p), 4'h5, hs};
        chk("central", far.got_tx[2*p+3], want);
      end
      chk("float D", far.got_oe[11], 8'hC0);
      chk("monitor", far.got_tx[12], 8'h3C);
      want = {6'h15, 2'h3 & hs};
      chk("transparent", far.got_tx[13], want);
      chk("sig down", far.got_tx[15], {6'h2D, hs});
      chk("up D", far.got_ptx[8] & 8'h0C, 8'h04);
      chk("up tristate", far.got_poe[8], 8'hF3);
    end
    $display("test switching done");
    // C/I and signaling change events, queue and interrupt
    apb(1'b0, A_STAT, 32'h0);
    chk("change flags", rd[7:0], 8'h03);
    chk("irq masked", {7'h0, irq}, 8'h00);
    apb(1'b0, A_QUEUE, 32'h0);
    chk("queue head", rd[7:0], 8'h83);
    apb(1'b0, A_QUEUE, 32'h0);
    chk("queue sig", rd[7:0], 8'h8F);
    apb(1'b0, A_QUEUE, 32'h0);
    chk("queue empty", {7'h0, rd[Q_VALID]}, 8'h00);
    apb(1'b1, A_MASK, 32'h1);
    repeat (3) @(posedge pclk);
    chk("irq unmasked", {7'h0, irq}, 8'h01);
    apb(1'b1, A_STAT, 32'h1);
    repeat (3) @(posedge pclk);
    chk("irq cleared", {7'h0, irq}, 8'h00);
    apb(1'b0, A_STAT, 32'h0);
    chk("ci cleared", rd[7:0], 8'h02);
    apb(1'b1, A_STAT, 32'h2);
    apb(1'b0, A_STAT, 32'h0);
    chk("status cleared", rd[7:0], 8'h00);
    $display("test interrupt done");
    give_verdict();
  end
endmodule : tb_top
